// ===== rtl/xad_decoder.sv
// Purpose: steer ext-data moves to on-chip ram/can area or external bus
// Assumes: cpu access inputs synchronous to mclk; apb slave for control
// Notes:   decode outputs registered, valid one cycle after request
//
// The register offsets and the APB register port are this design's own decisions.
`include "xad_regs.svh"
`timescale 1ns/1ps

module xad_decoder #(
   parameter int RAM_BYTES = `XAD_RAM_BYTES,
   parameter int CAN_BYTES = `XAD_CAN_BYTES
) (
   input  wire logic        mclk,          // 200 MHz clock
   input  wire logic        rstn,          // async reset, active low
   input  wire logic        clkEn,         // freezes all state when low
   input  wire logic        psel,          // apb select
   input  wire logic        penable,       // apb enable
   input  wire logic        pwrite,        // apb direction
   input  wire logic [11:0] paddr,         // apb byte address
   input  wire logic [31:0] pwdata,        // apb write data
   input  wire logic [3:0]  pstrb,         // apb byte strobes
   output logic      [31:0] prdata,        // apb read data
   output logic             pready,        // apb ready
   output logic             pslverr,       // apb error
   input  wire logic        moveReq,       // cpu ext-data move request
   input  wire logic        moveIndexed,   // 1: 8-bit index, 0: 16-bit pointer
   input  wire logic [15:0] pointer16,     // 16-bit pointer value
   input  wire logic [7:0]  indexAddr,     // 8-bit index register address
   input  wire logic        externalAccessPin, // external-access pin level
   output logic             selOnchip,     // on-chip ram/can selected
   output logic             selCan,        // can area within on-chip
   output logic [15:0]      effAddr,       // effective address
   output logic             strobeEn,      // read/write strobes pulse
   output logic             port0Bus,      // port 0 acts as bus
   output logic             port2Bus       // port 2 acts as bus
);

   // ******************************
   // parameter checks
   // ******************************
   // window runs from its start to the top of the 64 KB space
   if (RAM_BYTES + CAN_BYTES != 32'h0000_FFFF - `XAD_WIN_START + 1) begin : g_bad_window
      $error("window size must match ram plus can area");
   end
   // can area start must fall on a page boundary
   if (RAM_BYTES % 256 != 0) begin : g_bad_ram
      $error("ram size must be a whole number of pages");
   end

   // first address of the can area
   localparam logic [15:0] CAN_START = 16'(`XAD_WIN_START + RAM_BYTES);

   xad_pkg::xad_state_type cur;
   xad_pkg::xad_state_type nxt;

   logic [15:0] addrMux;
   logic        inWindow;
   logic        mapDis;
   logic        visBit;
   logic        onchip;
   logic        wordSel;
   logic        known;
   logic [31:0] rdWord;

   // ******************************
   // decode and apb
   // ******************************
   always_comb begin
      nxt = cur;
      addrMux = moveIndexed ? {cur.pageReg, indexAddr} : pointer16;
      if (moveIndexed)
         inWindow = (cur.pageReg >= `XAD_WIN_PAGE);
      else
         inWindow = (pointer16 >= `XAD_WIN_START);
      mapDis = cur.sysCtrl[`XAD_MAP_DIS_BIT];
      visBit = cur.sysCtrl[`XAD_STROBE_VIS_BIT];
      // visible bit plays no part in the steering itself
      onchip = inWindow && !mapDis;
      // map bits x1 -> external, 10 -> on-chip visible, 00 -> on-chip hidden
      if (moveReq) begin
         nxt.effAddr = addrMux;
         nxt.selOnchip = onchip;
         nxt.selCan = onchip && (addrMux >= CAN_START);
         case ({onchip, visBit})
            2'b10: begin
               // on-chip, hidden: strobes stay idle
               nxt.strobeEn = 1'b0;
               if (externalAccessPin) begin
                  // pin high: both ports stay general i/o
                  nxt.port0Bus = 1'b0;
                  nxt.port2Bus = 1'b0;
               end else if (moveIndexed) begin
                  // pin low, index access: port 0 carries data only
                  nxt.port0Bus = 1'b1;
                  nxt.port2Bus = 1'b0;
               end else begin
                  // pin low, pointer access: both ports carry data
                  nxt.port0Bus = 1'b1;
                  nxt.port2Bus = 1'b1;
               end
            end
            2'b11: begin
               // on-chip, visible: looks like a bus cycle outside
               nxt.strobeEn = 1'b1;
               nxt.port0Bus = 1'b1;
               nxt.port2Bus = !moveIndexed;
            end
            default: begin
               // external: bus cycle whatever the map bits
               nxt.strobeEn = 1'b1;
               nxt.port0Bus = 1'b1;
               nxt.port2Bus = !moveIndexed;
            end
         endcase
      end else begin
         nxt.selOnchip = 1'b0;
         nxt.selCan = 1'b0;
         nxt.strobeEn = 1'b0;
         nxt.port0Bus = 1'b0;
         nxt.port2Bus = 1'b0;
      end

      wordSel = (paddr[1:0] == 2'b00);
      known = wordSel && (paddr == `XAD_SYSCTRL_OFS || paddr == `XAD_PAGE_OFS || paddr == `XAD_STATUS_OFS);
      case (paddr)
         `XAD_SYSCTRL_OFS: rdWord = {24'h00_0000, cur.sysCtrl};
         `XAD_PAGE_OFS:    rdWord = {24'h00_0000, cur.pageReg};
         `XAD_STATUS_OFS:  rdWord = {26'h000_0000, cur.mapCleared, cur.port2Bus, cur.port0Bus,
                                     cur.strobeEn, cur.selCan, cur.selOnchip};
         default:          rdWord = 32'h0000_0000;
      endcase

      case (cur.apbState)
         xad_pkg::XAD_IDLE: begin
            nxt.pready = 1'b0;
            nxt.pslverr = 1'b0;
            if (psel && !penable)
               nxt.apbState = xad_pkg::XAD_ACCESS;
         end
         xad_pkg::XAD_ACCESS: begin
            nxt.pready = 1'b1;
            nxt.pslverr = !known;
            nxt.prdata = (!pwrite && known) ? rdWord : 32'h0000_0000;
            nxt.apbState = xad_pkg::XAD_DONE;
         end
         xad_pkg::XAD_DONE: begin
            nxt.pready = 1'b0;
            nxt.pslverr = 1'b0;
            nxt.apbState = xad_pkg::XAD_IDLE;
            if (pwrite && known && pstrb[0]) begin
               if (paddr == `XAD_SYSCTRL_OFS) begin
                  nxt.sysCtrl[7:2] = pwdata[7:2];
                  nxt.sysCtrl[`XAD_STROBE_VIS_BIT] = pwdata[`XAD_STROBE_VIS_BIT];
                  if (!cur.mapCleared) begin
                     nxt.sysCtrl[`XAD_MAP_DIS_BIT] = pwdata[`XAD_MAP_DIS_BIT];
                     nxt.mapCleared = !pwdata[`XAD_MAP_DIS_BIT];
                  end
               end else if (paddr == `XAD_PAGE_OFS) begin
                  nxt.pageReg = pwdata[7:0];
               end
            end
         end
         default: nxt.apbState = xad_pkg::XAD_IDLE;
      endcase
   end

   // ******************************
   // state register
   // ******************************
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cur <= '0;
         cur.apbState <= xad_pkg::XAD_IDLE;
         cur.sysCtrl <= `XAD_SYSCTRL_RST;
         cur.pageReg <= `XAD_PAGE_RST;
      end else if (clkEn) begin
         cur <= nxt;
      end
   end

   assign prdata = cur.prdata;
   assign pready = cur.pready;
   assign pslverr = cur.pslverr;
   assign selOnchip = cur.selOnchip;
   assign selCan = cur.selCan;
   assign effAddr = cur.effAddr;
   assign strobeEn = cur.strobeEn;
   assign port0Bus = cur.port0Bus;
   assign port2Bus = cur.port2Bus;

endmodule : xad_decoder

// ===== rtl/xad_regs.svh
// Purpose: constants for the on-chip external-data access decoder
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`ifndef XAD_REGS_SVH
`define XAD_REGS_SVH

// ******************************
// register map
// ******************************
`define XAD_SYSCTRL_OFS      12'h000
`define XAD_PAGE_OFS         12'h004
`define XAD_STATUS_OFS       12'h008
`define XAD_ADDR_W           12

// ******************************
// fields and reset values
// ******************************
`define XAD_STROBE_VIS_BIT   1
`define XAD_MAP_DIS_BIT      0
`define XAD_SYSCTRL_RST      8'h01
`define XAD_PAGE_RST         8'h00

// ******************************
// on-chip window
// ******************************
`define XAD_WIN_START        16'hF700
`define XAD_WIN_PAGE         8'hF7
`define XAD_RAM_BYTES        2048
`define XAD_CAN_BYTES        256

`endif

// ===== rtl/xad_pkg.sv
// Purpose: types for the on-chip external-data access decoder
// Assumes: constants live in xad_regs.svh
// Notes:   none
package xad_pkg;

   typedef enum logic [2:0] {
      XAD_IDLE   = 3'b001,
      XAD_ACCESS = 3'b010,
      XAD_DONE   = 3'b100
   } xad_apb_type;

   typedef struct packed {
      xad_apb_type apbState;
      logic [7:0]  sysCtrl;
      logic [7:0]  pageReg;
      logic        mapCleared;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        selOnchip;
      logic        strobeEn;
      logic        port0Bus;
      logic        port2Bus;
      logic [15:0] effAddr;
      logic        selCan;
   } xad_state_type;

endpackage : xad_pkg

// ===== sim/xad_decoder_properties.sv
// Purpose: port properties of the decoder
// Assumes: clkEn held high
// Notes:   bound from the bench
`timescale 1ns/1ps
module xad_decoder_properties (
   input wire logic        mclk,              // clock
   input wire logic        rstn,              // reset
   input wire logic        psel,              // apb
   input wire logic        penable,           // apb
   input wire logic        pready,            // apb
   input wire logic        moveReq,           // request
   input wire logic        moveIndexed,       // index mode
   input wire logic [15:0] pointer16,         // pointer
   input wire logic [7:0]  indexAddr,         // index
   input wire logic        externalAccessPin, // pin
   input wire logic        selOnchip,         // on-chip
   input wire logic        selCan,            // can
   input wire logic [15:0] effAddr,           // address
   input wire logic        strobeEn,          // strobes
   input wire logic        port0Bus,          // port 0
   input wire logic        port2Bus           // port 2
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence ext_s;
      !selOnchip && strobeEn && port0Bus && port2Bus;
   endsequence
   a_apb_answer: assert property (setup_s |=> !pready ##[1:2] pready) else $error("late ready");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
   a_ptr_addr: assert property (moveReq && !moveIndexed |=> effAddr == $past(pointer16))
      else $error("pointer address");
   a_idx_low: assert property (moveReq && moveIndexed |=> effAddr[7:0] == $past(indexAddr))
      else $error("index address");
   a_below_ext: assert property (moveReq && !moveIndexed && pointer16 < 16'hF700 |=> ext_s)
      else $error("low address not external");
   a_onchip_win: assert property (selOnchip |-> effAddr >= 16'hF700) else $error("outside window");
   a_can_top: assert property (selCan |-> effAddr[15:8] == 8'hFF) else $error("can area");
   a_hidden_ports: assert property (selOnchip && !strobeEn |-> port0Bus == !$past(externalAccessPin)
      && port2Bus == (!$past(externalAccessPin) && !$past(moveIndexed))) else $error("hidden ports");
   a_ext_strobes: assert property (!selOnchip && $past(moveReq) |-> strobeEn && port0Bus)
      else $error("external strobes");
   a_idle_quiet: assert property (!$past(moveReq) |-> !selOnchip && !strobeEn && !port0Bus)
      else $error("idle outputs");
endmodule : xad_decoder_properties

// ===== sim/xad_cpu_model.sv
// Purpose: cpu side issuing ext-data moves
// Assumes: one request per call
// Notes:   after release, pointer and index lines show inverted values
`timescale 1ns/1ps
module xad_cpu_model (
   input wire logic    mclk,              // clock
   output logic        moveReq,           // request
   output logic        moveIndexed,       // mode
   output logic [15:0] pointer16,         // pointer
   output logic [7:0]  indexAddr,         // index
   output logic        externalAccessPin  // pin level
);
   initial begin
      moveReq = 1'b0;
      moveIndexed = 1'b0;
      pointer16 = 16'h0;
      indexAddr = 8'h0;
      externalAccessPin = 1'b0;
   end
   task automatic issue(input logic ix, input logic [15:0] p, input logic [7:0] ia, input logic pin);
      @(posedge mclk);
      moveReq <= 1'b1;
      moveIndexed <= ix;
      pointer16 <= p;
      indexAddr <= ia;
      externalAccessPin <= pin;
      @(posedge mclk);
      moveReq <= 1'b0;
      pointer16 <= ~p;
      indexAddr <= ~ia;
   endtask : issue
endmodule : xad_cpu_model

// ===== sim/onchip_xdata_access_decoder_bench.sv
// Purpose: self-checking bench for the decoder
// Assumes: clkEn tied high, byte lane 0
// Notes:   apb master plus cpu model
`include "xad_regs.svh"
`timescale 1ns/1ps
module onchip_xdata_access_decoder_bench;
   logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic        moveReq, moveIndexed, externalAccessPin, selOnchip, selCan, strobeEn, port0Bus, port2Bus;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] pointer16, effAddr;
   logic [7:0]  indexAddr;
   int          n_mismatch = 0, num_checks = 0, cyc = 0;
   xad_decoder dut (.mclk, .rstn, .clkEn(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'h1),
      .prdata, .pready, .pslverr, .moveReq, .moveIndexed, .pointer16, .indexAddr, .externalAccessPin,
      .selOnchip, .selCan, .effAddr, .strobeEn, .port0Bus, .port2Bus);
   xad_cpu_model cpu (.mclk, .moveReq, .moveIndexed, .pointer16, .indexAddr, .externalAccessPin);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic mv(input logic ix, input logic [15:0] p, input logic [7:0] ia, input logic pin,
                     input logic [4:0] f, input logic [15:0] ea);
      cpu.issue(ix, p, ia, pin);
      #1;
      check({27'h0, selOnchip, selCan, strobeEn, port0Bus, port2Bus}, {27'h0, f});
      check({16'h0, effAddr}, {16'h0, ea});
   endtask : mv
   initial begin
      rstn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      apb(1'b0, `XAD_SYSCTRL_OFS, 32'h0); check(rd, 32'h1);
      apb(1'b0, `XAD_PAGE_OFS, 32'h0); check(rd, 32'h0);
      mv(1'b0, 16'hF700, 8'h0, 1'b0, 5'b00111, 16'hF700);
      $display("test reset done");
      apb(1'b1, `XAD_SYSCTRL_OFS, 32'h0); apb(1'b0, `XAD_SYSCTRL_OFS, 32'h0); check(rd, 32'h0);
      mv(1'b0, 16'hF700, 8'h0, 1'b0, 5'b10011, 16'hF700);
      mv(1'b0, 16'hF6FF, 8'h0, 1'b0, 5'b00111, 16'hF6FF);
      mv(1'b0, 16'hFFFF, 8'h0, 1'b1, 5'b11000, 16'hFFFF);
      apb(1'b1, `XAD_SYSCTRL_OFS, 32'h3); apb(1'b0, `XAD_SYSCTRL_OFS, 32'h0); check(rd, 32'h2);
      mv(1'b0, 16'hF700, 8'h0, 1'b1, 5'b10111, 16'hF700);
      $display("test window done");
      apb(1'b1, `XAD_PAGE_OFS, 32'hF6); mv(1'b1, 16'h0, 8'h12, 1'b0, 5'b00110, 16'hF612);
      apb(1'b1, `XAD_PAGE_OFS, 32'hF7); mv(1'b1, 16'h0, 8'h12, 1'b0, 5'b10110, 16'hF712);
      apb(1'b0, 12'h00C, 32'h0); check({31'h0, err}, 32'h1);
      $display("test page done");
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      apb(1'b0, `XAD_SYSCTRL_OFS, 32'h0); check(rd, 32'h1);
      mv(1'b0, 16'hF700, 8'h0, 1'b0, 5'b00111, 16'hF700);
      $display("test second reset done");
      stop_test();
   end
endmodule : onchip_xdata_access_decoder_bench
bind xad_decoder xad_decoder_properties chk (.mclk, .rstn, .psel, .penable, .pready, .moveReq, .moveIndexed,
   .pointer16, .indexAddr, .externalAccessPin, .selOnchip, .selCan, .effAddr, .strobeEn, .port0Bus, .port2Bus);
